// [isdc_pkg.sv]
// Shared constants and types for the impedance sweep DFT control block.
// Assumes a byte-wide register port at the printed offsets and a 20 MHz system clock.
package isdc_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL_HI   = 8'h80;
	localparam logic [7:0] ADDR_CTRL_LO   = 8'h81;
	localparam logic [7:0] ADDR_FIRST_HI  = 8'h82;
	localparam logic [7:0] ADDR_STEP_HI   = 8'h85;
	localparam logic [7:0] ADDR_COUNT_HI  = 8'h88;
	localparam logic [7:0] ADDR_SETTLE_HI = 8'h8A;
	localparam logic [7:0] ADDR_SETTLE_LO = 8'h8B;
	localparam logic [7:0] ADDR_STATUS    = 8'h8F;
	localparam logic [7:0] ADDR_REAL_HI   = 8'h94;
	localparam logic [7:0] ADDR_REAL_LO   = 8'h95;
	localparam logic [7:0] ADDR_IMAG_HI   = 8'h96;
	localparam logic [7:0] ADDR_IMAG_LO   = 8'h97;

	// Writable byte bank covers 0x80..0x8B
	localparam int         WBANK_DEPTH    = 12;
	localparam logic [7:0] BYTE_RESET     = 8'h00;

	// Command codes in control bits D15..D12
	localparam logic [3:0] CMD_INIT       = 4'h1;
	localparam logic [3:0] CMD_SWEEP      = 4'h2;
	localparam logic [3:0] CMD_STEP       = 4'h3;
	localparam logic [3:0] CMD_REPEAT     = 4'h4;
	localparam logic [3:0] CMD_POWERDOWN  = 4'hA;
	localparam logic [3:0] CMD_STANDBY    = 4'hB;

	// Status bit positions
	localparam int         STAT_POINT_BIT = 2;
	localparam int         STAT_SWEEP_BIT = 3;

	// Synthesis and DFT figures
	localparam int         PHASE_W        = 27;
	localparam int         WORD_W         = 24;
	localparam int         MCLK_DIV       = 16;
	localparam int         DFT_SAMPLES    = 1024;
	localparam int         SAMPLE_W       = 12;
	localparam int         REF_W          = 8;
	localparam int         ACC_W          = 30;
	localparam int         RESULT_W       = 16;
	localparam int         POINT_W        = 9;

	// High byte of the control register
	typedef struct packed {
		logic [3:0] cmd;
		logic       spare;
		logic [1:0] range;
		logic       gain_x1;
	} isdc_ctrl_t;

	// Sweep states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_STANDBY = 3'b001,
		ST_INIT    = 3'b011,
		ST_SETTLE  = 3'b010,
		ST_MEASURE = 3'b110,
		ST_PT_DONE = 3'b111,
		ST_SW_DONE = 3'b101
	} isdc_state_t;

endpackage

// [isdc_top.sv]
// Sweep sequencer, synthesis core and DFT engine of the impedance converter.
// Assumes a serial bus engine outside presents byte reads and writes on the register port,
// and ADC samples arrive as signed words with a one-cycle valid strobe on CLOCK.
// Operation
// - Point count is nine bits, max 511
// - Sweep starts only on begin-sweep command
// - Status D2 marks point measurement done
// - No self stepping; host reads results first
// - Repeat command remeasures at same frequency
// - D3 marks sweep end; steps then ignored
// - Standby grounds excitation and receive pins
// - Initialize excites start frequency, no measuring
// - Wait programmed output cycles before sampling
// - Control D10:D9 choose excitation range
// - Control D8 selects receive gain five/one
// - Multiply samples by cos/sin, sum 1024
// - Real, imaginary results signed 16-bit
// - 27-bit accumulator, start top bits zero
// - Synthesis clocked from external master clock
`timescale 1ns/1ps
module isdc_top #(
	parameter int DFT_SAMPLES = isdc_pkg::DFT_SAMPLES
) (
	input  wire logic                               CLOCK,
	input  wire logic                               RST,
	input  wire logic                               MCLK,
	input  wire logic [7:0]                         REG_ADDR,
	input  wire logic [7:0]                         REG_WDATA,
	input  wire logic                               REG_WE,
	input  wire logic                               REG_RE,
	output logic      [7:0]                         REG_RDATA,
	input  wire logic signed [isdc_pkg::SAMPLE_W-1:0] ADC_DATA,
	input  wire logic                               ADC_VALID,
	output logic                                    ADC_SAMPLE_EN,
	output logic      [isdc_pkg::REF_W-1:0]         EXCITATION_OUTPUT_CODE,
	output logic                                    EXCITATION_OUTPUT_GROUND,
	output logic                                    RECEIVE_INPUT_GROUND,
	output logic      [1:0]                         EXCITATION_RANGE,
	output logic                                    RECEIVE_GAIN_X5
);

	localparam int CNT_W = $clog2(DFT_SAMPLES + 1);

	// Signed cosine over sixteen phase steps, shared by both references
	function automatic logic signed [isdc_pkg::REF_W-1:0] cos_lut(input logic [3:0] idx);
		logic signed [isdc_pkg::REF_W-1:0] v;
		v = 8'sh00;
		unique case (idx)
			4'h0: v = 8'sh7F;
			4'h1: v = 8'sh75;
			4'h2: v = 8'sh5A;
			4'h3: v = 8'sh31;
			4'h4: v = 8'sh00;
			4'h5: v = -8'sh31;
			4'h6: v = -8'sh5A;
			4'h7: v = -8'sh75;
			4'h8: v = -8'sh7F;
			4'h9: v = -8'sh75;
			4'hA: v = -8'sh5A;
			4'hB: v = -8'sh31;
			4'hC: v = 8'sh00;
			4'hD: v = 8'sh31;
			4'hE: v = 8'sh5A;
			4'hF: v = 8'sh75;
		endcase
		return v;
	endfunction

	logic [7:0]                             wbank_r [isdc_pkg::WBANK_DEPTH];
	isdc_pkg::isdc_state_t                  state_r;
	logic                                   mclk_s1_r;
	logic                                   mclk_s2_r;
	logic                                   mclk_s3_r;
	logic                                   mclk_lvl_r;
	logic [3:0]                             div_r;
	logic [isdc_pkg::PHASE_W-1:0]           phase_r;
	logic [isdc_pkg::PHASE_W-1:0]           freq_r;
	logic                                   cycle_end_r;
	logic [15:0]                            settle_cnt_r;
	logic [CNT_W-1:0]                       sample_cnt_r;
	logic [isdc_pkg::POINT_W-1:0]           point_r;
	logic signed [isdc_pkg::ACC_W-1:0]      acc_re_r;
	logic signed [isdc_pkg::ACC_W-1:0]      acc_im_r;
	logic [isdc_pkg::RESULT_W-1:0]          real_r;
	logic [isdc_pkg::RESULT_W-1:0]          imag_r;
	logic                                   point_done_r;
	logic                                   sweep_done_r;

	logic                                   cmd_wr;
	isdc_pkg::isdc_ctrl_t                   ctrl;
	logic [isdc_pkg::WORD_W-1:0]            first_word;
	logic [isdc_pkg::WORD_W-1:0]            step_word;
	logic [isdc_pkg::POINT_W-1:0]           point_limit;
	logic [15:0]                            settle_limit;
	logic                                   mclk_rise;
	logic                                   dds_tick;
	logic [isdc_pkg::PHASE_W:0]             phase_sum;
	logic                                   excite_on;
	logic                                   meas_last;
	logic                                   step_ok;
	logic signed [isdc_pkg::REF_W-1:0]      ref_cos;
	logic signed [isdc_pkg::REF_W-1:0]      ref_sin;
	logic signed [isdc_pkg::SAMPLE_W+isdc_pkg::REF_W-1:0] prod_re;
	logic signed [isdc_pkg::SAMPLE_W+isdc_pkg::REF_W-1:0] prod_im;

	// Field views of the byte bank, most significant byte at lowest address
	assign ctrl         = isdc_pkg::isdc_ctrl_t'(wbank_r[0]);
	assign first_word   = {wbank_r[2], wbank_r[3], wbank_r[4]};
	assign step_word    = {wbank_r[5], wbank_r[6], wbank_r[7]};
	assign point_limit  = {wbank_r[8][0], wbank_r[9]};
	assign settle_limit = {wbank_r[10], wbank_r[11]};
	assign cmd_wr       = REG_WE && (REG_ADDR == isdc_pkg::ADDR_CTRL_HI);

	// Byte bank writes; only 0x80..0x8B are writable
	always_ff @(posedge CLOCK) begin
		for (int i = 0; i < isdc_pkg::WBANK_DEPTH; i++) begin
			if (RST) begin
				wbank_r[i] <= isdc_pkg::BYTE_RESET;
			end else if (REG_WE && (REG_ADDR == isdc_pkg::ADDR_CTRL_HI + 8'(i))) begin
				wbank_r[i] <= REG_WDATA;
			end
		end
	end

	// Read data, registered one cycle after the read strobe
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RE) begin
			if (REG_ADDR >= isdc_pkg::ADDR_CTRL_HI && REG_ADDR <= isdc_pkg::ADDR_SETTLE_LO) begin
				REG_RDATA <= wbank_r[4'(REG_ADDR - isdc_pkg::ADDR_CTRL_HI)];
			end else begin
				unique case (REG_ADDR)
					isdc_pkg::ADDR_STATUS:  REG_RDATA <= {4'h0, sweep_done_r, point_done_r, 2'b00};
					isdc_pkg::ADDR_REAL_HI: REG_RDATA <= real_r[15:8];
					isdc_pkg::ADDR_REAL_LO: REG_RDATA <= real_r[7:0];
					isdc_pkg::ADDR_IMAG_HI: REG_RDATA <= imag_r[15:8];
					isdc_pkg::ADDR_IMAG_LO: REG_RDATA <= imag_r[7:0];
					default:                REG_RDATA <= 8'h00;
				endcase
			end
		end
	end

	// Master clock synchroniser; level moves when the second and third stages agree
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mclk_s1_r  <= 1'b0;
			mclk_s2_r  <= 1'b0;
			mclk_s3_r  <= 1'b0;
			mclk_lvl_r <= 1'b0;
		end else begin
			mclk_s1_r <= MCLK;
			mclk_s2_r <= mclk_s1_r;
			mclk_s3_r <= mclk_s2_r;
			if (mclk_s2_r == mclk_s3_r) begin
				mclk_lvl_r <= mclk_s3_r;
			end
		end
	end

	// Master clock edge, synthesis tick and excitation enable
	assign mclk_rise = (mclk_s2_r == mclk_s3_r) && mclk_s3_r && !mclk_lvl_r;
	assign dds_tick  = mclk_rise && (div_r == 4'(isdc_pkg::MCLK_DIV - 1));
	assign excite_on = (state_r == isdc_pkg::ST_INIT) || (state_r == isdc_pkg::ST_SETTLE) ||
	                   (state_r == isdc_pkg::ST_MEASURE) || (state_r == isdc_pkg::ST_PT_DONE) ||
	                   (state_r == isdc_pkg::ST_SW_DONE);
	assign phase_sum = {1'b0, phase_r} + {1'b0, freq_r};

	// Synthesis core steps at master clock over sixteen
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			div_r       <= 4'h0;
			phase_r     <= '0;
			cycle_end_r <= 1'b0;
		end else begin
			cycle_end_r <= 1'b0;
			if (mclk_rise) begin
				div_r <= div_r + 4'h1;
			end
			if (!excite_on) begin
				phase_r <= '0;
			end else if (dds_tick) begin
				phase_r     <= phase_sum[isdc_pkg::PHASE_W-1:0];
				cycle_end_r <= phase_sum[isdc_pkg::PHASE_W]; // One output cycle ends at wrap
			end
		end
	end

	// Step accepted only while a point result waits, never after the sweep ends
	assign step_ok = (state_r == isdc_pkg::ST_PT_DONE) && cmd_wr && (REG_WDATA[7:4] == isdc_pkg::CMD_STEP);

	// Current frequency word; top three bits stay zero at start
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			freq_r <= '0;
		end else if (cmd_wr && (REG_WDATA[7:4] == isdc_pkg::CMD_INIT ||
		             (REG_WDATA[7:4] == isdc_pkg::CMD_SWEEP && state_r != isdc_pkg::ST_INIT))) begin
			freq_r <= {3'b000, first_word};
		end else if (step_ok) begin
			freq_r <= freq_r + {3'b000, step_word};
		end
	end

	// Last sample of the sum is arriving
	assign meas_last = ADC_VALID && (sample_cnt_r == CNT_W'(DFT_SAMPLES - 1));

	// Sweep sequencer
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_r <= isdc_pkg::ST_IDLE;
		end else if (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_STANDBY) begin
			state_r <= isdc_pkg::ST_STANDBY;
		end else if (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_POWERDOWN) begin
			state_r <= isdc_pkg::ST_IDLE;
		end else if (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_INIT) begin
			state_r <= isdc_pkg::ST_INIT;
		end else if (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_SWEEP) begin
			state_r <= isdc_pkg::ST_SETTLE;
		end else begin
			unique case (state_r)
				isdc_pkg::ST_IDLE, isdc_pkg::ST_STANDBY, isdc_pkg::ST_INIT: begin
					state_r <= state_r; // Only a command moves on
				end
				isdc_pkg::ST_SETTLE: begin
					if (settle_cnt_r >= settle_limit) begin
						state_r <= isdc_pkg::ST_MEASURE;
					end
				end
				isdc_pkg::ST_MEASURE: begin
					if (meas_last) begin
						state_r <= (point_r >= point_limit) ? isdc_pkg::ST_SW_DONE : isdc_pkg::ST_PT_DONE;
					end
				end
				isdc_pkg::ST_PT_DONE: begin
					if (step_ok || (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_REPEAT)) begin
						state_r <= isdc_pkg::ST_SETTLE;
					end
				end
				isdc_pkg::ST_SW_DONE: begin
					if (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_REPEAT) begin
						state_r <= isdc_pkg::ST_SETTLE; // Steps are ignored here
					end
				end
				default: state_r <= isdc_pkg::ST_IDLE;
			endcase
		end
	end

	// Settling counter counts whole output cycles
	always_ff @(posedge CLOCK) begin
		if (RST || state_r != isdc_pkg::ST_SETTLE) begin
			settle_cnt_r <= 16'h0000;
		end else if (cycle_end_r) begin
			settle_cnt_r <= settle_cnt_r + 16'h0001;
		end
	end

	// Point index, advanced by accepted steps only
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			point_r <= '0;
		end else if (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_SWEEP) begin
			point_r <= '0;
		end else if (step_ok) begin
			point_r <= point_r + 9'h001;
		end
	end

	// Reference pair; sine is the cosine a quarter turn back
	assign ref_cos = cos_lut(phase_r[isdc_pkg::PHASE_W-1 -: 4]);
	assign ref_sin = cos_lut(phase_r[isdc_pkg::PHASE_W-1 -: 4] - 4'h4);
	assign prod_re = ADC_DATA * ref_cos;
	assign prod_im = ADC_DATA * ref_sin;

	// DFT accumulation: real adds x*cos, imaginary subtracts x*sin
	always_ff @(posedge CLOCK) begin
		if (RST || state_r != isdc_pkg::ST_MEASURE) begin
			acc_re_r     <= '0;
			acc_im_r     <= '0;
			sample_cnt_r <= '0;
		end else if (ADC_VALID) begin
			acc_re_r     <= acc_re_r + isdc_pkg::ACC_W'(prod_re);
			acc_im_r     <= acc_im_r - isdc_pkg::ACC_W'(prod_im);
			sample_cnt_r <= sample_cnt_r + CNT_W'(1);
		end
	end

	// Results latched at the last sample, two's complement top bits
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			real_r <= '0;
			imag_r <= '0;
		end else if (state_r == isdc_pkg::ST_MEASURE && meas_last) begin
			real_r <= 16'(($signed(acc_re_r) + isdc_pkg::ACC_W'(prod_re)) >>> 14);
			imag_r <= 16'(($signed(acc_im_r) - isdc_pkg::ACC_W'(prod_im)) >>> 14);
		end
	end

	// Status flags; a finishing measurement wins over a clearing command
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			point_done_r <= 1'b0;
			sweep_done_r <= 1'b0;
		end else if (state_r == isdc_pkg::ST_MEASURE && meas_last) begin
			point_done_r <= 1'b1;
			if (point_r >= point_limit) begin
				sweep_done_r <= 1'b1;
			end
		end else if (cmd_wr && (REG_WDATA[7:4] == isdc_pkg::CMD_SWEEP || REG_WDATA[7:4] == isdc_pkg::CMD_INIT ||
		             REG_WDATA[7:4] == isdc_pkg::CMD_STANDBY)) begin
			point_done_r <= 1'b0;
			sweep_done_r <= 1'b0;
		end else if (step_ok || (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_REPEAT &&
		             (state_r == isdc_pkg::ST_PT_DONE || state_r == isdc_pkg::ST_SW_DONE))) begin
			point_done_r <= 1'b0;
		end
	end

	// Analog path controls, all registered
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ADC_SAMPLE_EN            <= 1'b0;
			EXCITATION_OUTPUT_CODE   <= 8'h00;
			EXCITATION_OUTPUT_GROUND <= 1'b0;
			RECEIVE_INPUT_GROUND     <= 1'b0;
			EXCITATION_RANGE         <= 2'b00;
			RECEIVE_GAIN_X5          <= 1'b0;
		end else begin
			ADC_SAMPLE_EN            <= (state_r == isdc_pkg::ST_MEASURE) && !meas_last;
			EXCITATION_OUTPUT_CODE   <= excite_on ? ref_cos : 8'h00;
			EXCITATION_OUTPUT_GROUND <= (state_r == isdc_pkg::ST_STANDBY);
			RECEIVE_INPUT_GROUND     <= (state_r == isdc_pkg::ST_STANDBY);
			EXCITATION_RANGE         <= ctrl.range;
			RECEIVE_GAIN_X5          <= !ctrl.gain_x1;
		end
	end

endmodule

// [isdc_top_asserts.sv]
// Port assertions for the impedance sweep control block.
// Bound to isdc_top from the testbench; sees only the top module's ports.
`timescale 1ns/1ps
module isdc_top_asserts #(
	parameter int DFT_SAMPLES = 1024
) (
	input wire logic               CLOCK,
	input wire logic               RST,
	input wire logic               MCLK,
	input wire logic [7:0]         REG_ADDR,
	input wire logic [7:0]         REG_WDATA,
	input wire logic               REG_WE,
	input wire logic               REG_RE,
	input wire logic [7:0]         REG_RDATA,
	input wire logic signed [11:0] ADC_DATA,
	input wire logic               ADC_VALID,
	input wire logic               ADC_SAMPLE_EN,
	input wire logic [7:0]         EXCITATION_OUTPUT_CODE,
	input wire logic               EXCITATION_OUTPUT_GROUND,
	input wire logic               RECEIVE_INPUT_GROUND,
	input wire logic [1:0]         EXCITATION_RANGE,
	input wire logic               RECEIVE_GAIN_X5
);
	logic        swept_r;
	logic [11:0] taken_r;
	wire logic   cmd_wr = REG_WE && REG_ADDR == 8'h80;
	wire logic   init_wr = cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_INIT;
	wire logic   go_wr = cmd_wr && REG_WDATA[7:4] inside {isdc_pkg::CMD_SWEEP, isdc_pkg::CMD_STEP, isdc_pkg::CMD_REPEAT};

	// Notes a begin-sweep since the last init, standby or power down
	always_ff @(posedge CLOCK) begin
		if (RST || (cmd_wr && REG_WDATA[7:4] inside {4'h1, 4'hA, 4'hB}))
			swept_r <= 1'b0;
		else if (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_SWEEP)
			swept_r <= 1'b1;
	end

	// Counts samples taken during one measurement
	always_ff @(posedge CLOCK) begin
		if (RST || !ADC_SAMPLE_EN)
			taken_r <= 12'h000;
		else if (ADC_VALID)
			taken_r <= taken_r + 12'h001;
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	chk_range_copy: assert property (cmd_wr |-> ##2 EXCITATION_RANGE == $past(REG_WDATA[2:1], 2))
		else $error("range pins differ from control bits");
	chk_gain_sense: assert property (cmd_wr |-> ##2 RECEIVE_GAIN_X5 == !$past(REG_WDATA[0], 2))
		else $error("gain pin differs from control bit");
	chk_status_spare: assert property (REG_RE && REG_ADDR == 8'h8F |=> (REG_RDATA & 8'hF3) == 8'h00)
		else $error("status shows an unused bit");
	chk_standby_ground: assert property (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_STANDBY
		|=> ##1 EXCITATION_OUTPUT_GROUND && RECEIVE_INPUT_GROUND) else $error("standby did not ground pins");
	chk_ground_mute: assert property (EXCITATION_OUTPUT_GROUND [*2]
		|-> !ADC_SAMPLE_EN && EXCITATION_OUTPUT_CODE == 8'h00) else $error("grounded but active");
	chk_init_idle: assert property (init_wr |=> ##1 (!ADC_SAMPLE_EN && !EXCITATION_OUTPUT_GROUND) [*8])
		else $error("init sampled or stayed grounded");
	chk_settle_first: assert property (go_wr |=> ##1 !ADC_SAMPLE_EN)
		else $error("sampling began without settling");
	chk_sample_cause: assert property ($rose(ADC_SAMPLE_EN) |-> swept_r)
		else $error("sampling without begin-sweep");
	chk_sample_stop: assert property (ADC_VALID && ADC_SAMPLE_EN && taken_r == DFT_SAMPLES - 1
		|=> ##1 !ADC_SAMPLE_EN [*2]) else $error("sampling went on past the sum length");
	chk_no_early_stop: assert property ($fell(ADC_SAMPLE_EN) |-> taken_r == DFT_SAMPLES)
		else $error("sampling stopped short");

	cov_sweep: cover property (cmd_wr && REG_WDATA[7:4] == isdc_pkg::CMD_SWEEP);
	cov_measured: cover property ($fell(ADC_SAMPLE_EN));
	cov_init: cover property (init_wr);
endmodule

// [isdc_host_model.sv]
// Host and converter model facing the impedance sweep control block.
// Runs on the block's system clock; the master clock runs free at 400 ns.
`timescale 1ns/1ps
module isdc_host_model (
	input  wire logic          clock,
	input  wire logic          sample_en,
	input  wire logic [7:0]    rdata,
	input  wire logic [11:0]   sample_word,
	output logic               mclk,
	output logic [7:0]         addr,
	output logic [7:0]         wdata,
	output logic               we,
	output logic               re,
	output logic signed [11:0] adc_data,
	output logic               adc_valid
);
	int         pulse_cnt;
	logic [1:0] gap;

	// Quiet bus and converter at time zero
	initial begin
		{addr, wdata, we, re, adc_valid, gap} = '0;
		adc_data = 12'h000;
		pulse_cnt = 0;
		mclk = 1'b0;
	end

	// Master clock for the synthesis core, phase unrelated to the system clock
	initial begin
		#7;
		forever #200 mclk = ~mclk;
	end

	// One sample every fourth cycle while wanted; idle data toggles
	always @(posedge clock) begin
		#2;
		gap = gap + 2'h1;
		adc_valid = sample_en && gap == 2'h0;
		if (adc_valid) begin
			adc_data = sample_word;
			pulse_cnt++;
		end else begin
			adc_data = ~adc_data;
		end
	end

	// Byte write, strobe held for one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#2;
		{addr, wdata, we} = {a, d, 1'b1};
		@(posedge clock);
		#2;
		we = 1'b0;
		wdata = ~d;
	endtask

	// Byte read, data taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		#2;
		{addr, re} = {a, 1'b1};
		@(posedge clock);
		#2;
		re = 1'b0;
		d = rdata;
	endtask

	// Three-byte word, most significant byte at the lowest address
	task automatic wr_word(input logic [7:0] a, input logic [23:0] v);
		wr(a, v[23:16]);
		wr(a + 8'h01, v[15:8]);
		wr(a + 8'h02, v[7:0]);
	endtask
endmodule

// [isdc_top_test.sv]
// Self-checking testbench for the impedance sweep control block.
// Drives it through the host and converter model; the checker is bound at the foot.
`timescale 1ns/1ps
module isdc_top_test;
	localparam int      NSAMP = 16;
	logic               CLOCK;
	logic               RST;
	logic               MCLK;
	logic [7:0]         REG_ADDR, REG_WDATA, REG_RDATA, EXCITATION_OUTPUT_CODE, b;
	logic               REG_WE, REG_RE, ADC_VALID, ADC_SAMPLE_EN, RECEIVE_GAIN_X5;
	logic signed [11:0] ADC_DATA;
	logic               EXCITATION_OUTPUT_GROUND, RECEIVE_INPUT_GROUND;
	logic [1:0]         EXCITATION_RANGE;
	logic [11:0]        sample_word;
	logic [31:0]        seed;
	logic [15:0]        w;
	int                 errors, compares;

	isdc_host_model isdc_host_model_i (.clock(CLOCK), .sample_en(ADC_SAMPLE_EN), .rdata(REG_RDATA),
		.sample_word(sample_word), .mclk(MCLK), .addr(REG_ADDR), .wdata(REG_WDATA), .we(REG_WE), .re(REG_RE),
		.adc_data(ADC_DATA), .adc_valid(ADC_VALID));
	isdc_top #(.DFT_SAMPLES(NSAMP)) isdc_top_i (.CLOCK(CLOCK), .RST(RST), .MCLK(MCLK), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .ADC_DATA(ADC_DATA),
		.ADC_VALID(ADC_VALID), .ADC_SAMPLE_EN(ADC_SAMPLE_EN), .EXCITATION_OUTPUT_CODE(EXCITATION_OUTPUT_CODE),
		.EXCITATION_OUTPUT_GROUND(EXCITATION_OUTPUT_GROUND), .RECEIVE_INPUT_GROUND(RECEIVE_INPUT_GROUND),
		.EXCITATION_RANGE(EXCITATION_RANGE), .RECEIVE_GAIN_X5(RECEIVE_GAIN_X5));

	// System clock, 50 ns period
	always #25 CLOCK = ~CLOCK;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Frequency word for a 2.5 MHz master clock: hz / (mclk / 16) * 2^27
	function automatic logic [23:0] freq_word(input logic [63:0] hz);
		return 24'((hz << 31) / 64'h2625A0);
	endfunction

	function automatic logic [7:0] stat(input logic d2, input logic d3);
		return (8'(d2) << isdc_pkg::STAT_POINT_BIT) | (8'(d3) << isdc_pkg::STAT_SWEEP_BIT);
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		isdc_host_model_i.rd(a, v[15:8]);
		isdc_host_model_i.rd(a + 8'h01, v[7:0]);
	endtask

	task automatic cmd(input logic [3:0] c);
		isdc_host_model_i.wr(isdc_pkg::ADDR_CTRL_HI, {c, 4'h0});
	endtask

	// Issues a point command, polls for the point flag, counts samples
	task automatic point(input logic [3:0] c, input logic [7:0] exp, input logic [11:0] sw);
		int n;
		sample_word = sw;
		isdc_host_model_i.pulse_cnt = 0;
		cmd(c);
		isdc_host_model_i.rd(isdc_pkg::ADDR_STATUS, b);
		check("point flag cleared", 16'(b[2]), 16'h0000);
		n = 0;
		while (b[isdc_pkg::STAT_POINT_BIT] !== 1'b1 && n < 3000) begin
			isdc_host_model_i.rd(isdc_pkg::ADDR_STATUS, b);
			n++;
		end
		check("point status", 16'(b), 16'(exp));
		check("sample count", 16'(isdc_host_model_i.pulse_cnt), 16'(NSAMP));
		rd16(isdc_pkg::ADDR_REAL_HI, w);
		rd16(isdc_pkg::ADDR_IMAG_HI, w);
		$display("test point %h done", c);
	endtask

	// Watchdog
	initial begin
		#4000000;
		errors++;
		results();
	end

	initial begin
		CLOCK = 1'b0;
		RST = 1'b1;
		seed = 32'h00018320;
		sample_word = 12'h000;
		errors = 0;
		compares = 0;
		repeat (16) @(posedge CLOCK);
		#2;
		RST = 1'b0;
		// Writable bytes 0x82..0x8B except 0x88 read back; refused and unmapped places read zero
		for (int a = 8'h82; a <= 8'h8B; a++) begin
			if (a == 8'h88)
				continue;
			b = 8'(rnd());
			isdc_host_model_i.wr(8'(a), b);
			isdc_host_model_i.rd(8'(a), w[7:0]);
			check("byte readback", 16'(w[7:0]), 16'(b));
		end
		isdc_host_model_i.wr(8'h8C, 8'h5A);
		isdc_host_model_i.rd(8'h8C, b);
		check("refused byte", 16'(b), 16'h0000);
		isdc_host_model_i.rd(8'h40, b);
		check("unmapped byte", 16'(b), 16'h0000);
		$display("test registers done");
		// Every range and gain setting reaches its pins
		for (int i = 0; i < 8; i++) begin
			isdc_host_model_i.wr(isdc_pkg::ADDR_CTRL_HI, {5'h00, 3'(i)});
			isdc_host_model_i.wr(isdc_pkg::ADDR_CTRL_LO, 8'(rnd()));
			check("range", 16'(EXCITATION_RANGE), 16'(i[2:1]));
			check("gain", 16'(RECEIVE_GAIN_X5), 16'(!i[0]));
		end
		$display("test range and gain done");
		// Two-point sweep with two settle cycles, random step
		isdc_host_model_i.wr_word(isdc_pkg::ADDR_FIRST_HI, freq_word(64'h4A38));
		isdc_host_model_i.wr_word(isdc_pkg::ADDR_STEP_HI, 24'(rnd()) & 24'h000FFF);
		isdc_host_model_i.wr_word(isdc_pkg::ADDR_COUNT_HI, 24'h000100);
		isdc_host_model_i.wr(isdc_pkg::ADDR_SETTLE_HI, 8'h00);
		isdc_host_model_i.wr(isdc_pkg::ADDR_SETTLE_LO, 8'h02);
		cmd(isdc_pkg::CMD_STANDBY);
		@(posedge CLOCK);
		#2;
		check("excitation ground", 16'(EXCITATION_OUTPUT_GROUND), 16'h0001);
		check("receive ground", 16'(RECEIVE_INPUT_GROUND), 16'h0001);
		cmd(isdc_pkg::CMD_INIT);
		repeat (12) @(posedge CLOCK);
		#2;
		check("init ground", 16'(EXCITATION_OUTPUT_GROUND), 16'h0000);
		check("init sampling", 16'(ADC_SAMPLE_EN), 16'h0000);
		$display("test standby and init done");
		point(isdc_pkg::CMD_SWEEP, stat(1'b1, 1'b0), 12'h000);
		rd16(isdc_pkg::ADDR_REAL_HI, w);
		check("real of silence", w, 16'h0000);
		rd16(isdc_pkg::ADDR_IMAG_HI, w);
		check("imag of silence", w, 16'h0000);
		point(isdc_pkg::CMD_REPEAT, stat(1'b1, 1'b0), 12'(rnd()));
		point(isdc_pkg::CMD_STEP, stat(1'b1, 1'b1), 12'(rnd()));
		// Step after the last point is ignored; long enough for a wrongly started point to sample
		isdc_host_model_i.pulse_cnt = 0;
		cmd(isdc_pkg::CMD_STEP);
		repeat (3000) @(posedge CLOCK);
		#2;
		check("no sampling after end", 16'(ADC_SAMPLE_EN), 16'h0000);
		check("no samples after end", 16'(isdc_host_model_i.pulse_cnt), 16'h0000);
		isdc_host_model_i.rd(isdc_pkg::ADDR_STATUS, b);
		check("end status", 16'(b), 16'(stat(1'b1, 1'b1)));
		$display("test step after end done");
		point(isdc_pkg::CMD_REPEAT, stat(1'b1, 1'b1), 12'h000);
		results();
	end
endmodule

bind isdc_top isdc_top_asserts #(.DFT_SAMPLES(DFT_SAMPLES)) isdc_top_asserts_i (.CLOCK(CLOCK), .RST(RST),
	.MCLK(MCLK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
	.REG_RDATA(REG_RDATA), .ADC_DATA(ADC_DATA), .ADC_VALID(ADC_VALID), .ADC_SAMPLE_EN(ADC_SAMPLE_EN),
	.EXCITATION_OUTPUT_CODE(EXCITATION_OUTPUT_CODE), .EXCITATION_OUTPUT_GROUND(EXCITATION_OUTPUT_GROUND),
	.RECEIVE_INPUT_GROUND(RECEIVE_INPUT_GROUND), .EXCITATION_RANGE(EXCITATION_RANGE),
	.RECEIVE_GAIN_X5(RECEIVE_GAIN_X5));
